// *** logic/pmseq_top.sv ***
// pmseq_top: hardware power mode sequencer for the core and peripherals
// assumes always-on supply and clock; core, memories, switches are outside
`timescale 1ns/1ps
module pmseq_top (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // mode request from software
  input wire logic [1:0] MODE_SEL_I,
  input wire logic MODE_REQ_I,
  // wake sources
  input wire logic [pmseq_pkg::NUM_EXT_WAKE-1:0] EXT_IRQ_I,
  input wire logic [pmseq_pkg::NUM_TMR_WAKE-1:0] TMR_IRQ_I,
  input wire logic [pmseq_pkg::NUM_EXT_WAKE+pmseq_pkg::NUM_TMR_WAKE-1:0] WAKE_EN_I,
  input wire logic SYS_IRQ_I,
  // core domain control
  output logic CORE_PWR_EN_O,
  output logic CORE_CLK_EN_O,
  output logic CORE_ISO_O,
  output logic CORE_RST_O,
  output logic COLD_BOOT_O,
  // memory retention and peripherals
  output logic MEM_PWR_EN_O,
  output logic MEM_RET_O,
  output logic PERIPH_PWR_EN_O,
  output logic PERIPH_CLK_EN_O,
  // status
  output logic [1:0] MODE_O,
  output logic BUSY_O,
  output logic [pmseq_pkg::NUM_EXT_WAKE+pmseq_pkg::NUM_TMR_WAKE-1:0] WAKE_CAUSE_O
);

  localparam int NW = pmseq_pkg::NUM_EXT_WAKE + pmseq_pkg::NUM_TMR_WAKE;

  pmseq_pkg::pmseq_state_t state;
  pmseq_pkg::pmseq_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic from_shutdown;
  logic next_from_shutdown;
  logic [NW-1:0] cause;
  logic [NW-1:0] next_cause;
  logic [1:0] mode;
  logic [1:0] next_mode;

  logic core_pwr, core_clk, core_iso, core_rst, mem_pwr, mem_ret;
  logic per_pwr, per_clk, cold_boot;
  logic next_core_pwr, next_core_clk, next_core_iso, next_core_rst;
  logic next_mem_pwr, next_mem_ret, next_per_pwr, next_per_clk, next_cold_boot;

  logic arm;
  logic wake_clear;
  logic wake;
  logic [NW-1:0] latched;

  ////////////////////////////////////////////////////////////////////
  // wake sources: pins and timers share one latch bank
  pmseq_wake_gate #(
    .N(NW)
  ) u_wake (
    .SYS_CLK_I(SYS_CLK_I),
    .RESET_I(RESET_I),
    .src_i({TMR_IRQ_I, EXT_IRQ_I}),
    .enable_i(WAKE_EN_I),
    .arm_i(arm),
    .clear_i(wake_clear),
    .latched_o(latched),
    .wake_o(wake)
  );

  // armed only once fully down; earlier edges must not half-abort
  assign arm = (state == pmseq_pkg::PMSEQ_ST_SLEEP) || (state == pmseq_pkg::PMSEQ_ST_SHUTDOWN);
  assign wake_clear = (state == pmseq_pkg::PMSEQ_ST_ACTIVE) && MODE_REQ_I;

  ////////////////////////////////////////////////////////////////////
  // sequencing state machine
  always_comb begin
    next_state = state;
    next_cnt = (cnt != pmseq_pkg::CNT_ZERO) ? cnt - pmseq_pkg::CNT_ONE : pmseq_pkg::CNT_ZERO;
    next_from_shutdown = from_shutdown;
    next_cause = cause;
    next_mode = mode;
    unique case (state)
      pmseq_pkg::PMSEQ_ST_ACTIVE: begin
        if (MODE_REQ_I) begin
          unique case (pmseq_pkg::pmseq_mode_t'(MODE_SEL_I))
            pmseq_pkg::PMSEQ_MODE_STANDBY: begin
              next_state = pmseq_pkg::PMSEQ_ST_STBY;
              next_mode = pmseq_pkg::PMSEQ_MODE_STANDBY;
            end
            pmseq_pkg::PMSEQ_MODE_SLEEP: begin
              next_state = pmseq_pkg::PMSEQ_ST_SLP_ISO;
              next_cnt = pmseq_pkg::SETTLE_CYC;
            end
            pmseq_pkg::PMSEQ_MODE_SHUTDOWN: begin
              next_state = pmseq_pkg::PMSEQ_ST_SHD_ISO;
              next_cnt = pmseq_pkg::SETTLE_CYC;
            end
            pmseq_pkg::PMSEQ_MODE_ACTIVE: begin
              next_state = pmseq_pkg::PMSEQ_ST_ACTIVE;
            end
          endcase
        end
      end
      pmseq_pkg::PMSEQ_ST_STBY: begin
        if (SYS_IRQ_I) begin
          next_state = pmseq_pkg::PMSEQ_ST_ACTIVE;
          next_mode = pmseq_pkg::PMSEQ_MODE_ACTIVE;
        end
      end
      pmseq_pkg::PMSEQ_ST_SLP_ISO: begin
        if (cnt == pmseq_pkg::CNT_ZERO) begin
          next_state = pmseq_pkg::PMSEQ_ST_SLP_RET;
          next_cnt = pmseq_pkg::SETTLE_CYC;
        end
      end
      pmseq_pkg::PMSEQ_ST_SLP_RET: begin
        if (cnt == pmseq_pkg::CNT_ZERO) begin
          next_state = pmseq_pkg::PMSEQ_ST_SLP_OFF;
          next_cnt = pmseq_pkg::SETTLE_CYC;
        end
      end
      pmseq_pkg::PMSEQ_ST_SLP_OFF: begin
        if (cnt == pmseq_pkg::CNT_ZERO) begin
          next_state = pmseq_pkg::PMSEQ_ST_SLEEP;
          next_mode = pmseq_pkg::PMSEQ_MODE_SLEEP;
          next_from_shutdown = 1'b0;
        end
      end
      pmseq_pkg::PMSEQ_ST_SHD_ISO: begin
        if (cnt == pmseq_pkg::CNT_ZERO) begin
          next_state = pmseq_pkg::PMSEQ_ST_SHD_OFF;
          next_cnt = pmseq_pkg::SETTLE_CYC;
        end
      end
      pmseq_pkg::PMSEQ_ST_SHD_OFF: begin
        if (cnt == pmseq_pkg::CNT_ZERO) begin
          next_state = pmseq_pkg::PMSEQ_ST_SHUTDOWN;
          next_mode = pmseq_pkg::PMSEQ_MODE_SHUTDOWN;
          next_from_shutdown = 1'b1;
        end
      end
      pmseq_pkg::PMSEQ_ST_SLEEP, pmseq_pkg::PMSEQ_ST_SHUTDOWN: begin
        if (wake) begin
          next_state = pmseq_pkg::PMSEQ_ST_UP_ON;
          next_cnt = pmseq_pkg::SETTLE_CYC;
          next_cause = latched;
        end
      end
      pmseq_pkg::PMSEQ_ST_UP_ON: begin
        if (cnt == pmseq_pkg::CNT_ZERO) begin
          next_state = pmseq_pkg::PMSEQ_ST_UP_RST;
          next_cnt = pmseq_pkg::RST_HOLD_CYC;
        end
      end
      pmseq_pkg::PMSEQ_ST_UP_RST: begin
        if (cnt == pmseq_pkg::CNT_ZERO) begin
          next_state = pmseq_pkg::PMSEQ_ST_UP_CLK;
        end
      end
      pmseq_pkg::PMSEQ_ST_UP_CLK: begin
        next_state = pmseq_pkg::PMSEQ_ST_ACTIVE;
        next_mode = pmseq_pkg::PMSEQ_MODE_ACTIVE;
      end
      default: begin
        next_state = pmseq_pkg::PMSEQ_ST_ACTIVE;
        next_mode = pmseq_pkg::PMSEQ_MODE_ACTIVE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // switch outputs from the next state, so outputs are registered
  always_comb begin
    next_core_pwr = 1'b1;
    next_core_clk = 1'b1;
    next_core_iso = 1'b0;
    next_core_rst = 1'b0;
    next_mem_pwr = 1'b1;
    next_mem_ret = 1'b0;
    next_per_pwr = 1'b1;
    next_per_clk = 1'b1;
    next_cold_boot = cold_boot;
    unique case (next_state)
      pmseq_pkg::PMSEQ_ST_ACTIVE: begin
        next_core_clk = 1'b1;
      end
      pmseq_pkg::PMSEQ_ST_STBY: begin
        next_core_clk = 1'b0;
      end
      pmseq_pkg::PMSEQ_ST_SLP_ISO, pmseq_pkg::PMSEQ_ST_SHD_ISO: begin
        next_core_clk = 1'b0;
        next_core_iso = 1'b1;
      end
      pmseq_pkg::PMSEQ_ST_SLP_RET: begin
        next_core_clk = 1'b0;
        next_core_iso = 1'b1;
        next_mem_ret = 1'b1;
      end
      pmseq_pkg::PMSEQ_ST_SLP_OFF, pmseq_pkg::PMSEQ_ST_SLEEP: begin
        next_core_clk = 1'b0;
        next_core_iso = 1'b1;
        next_core_pwr = 1'b0;
        next_core_rst = 1'b1;
        next_mem_ret = 1'b1;
      end
      pmseq_pkg::PMSEQ_ST_SHD_OFF, pmseq_pkg::PMSEQ_ST_SHUTDOWN: begin
        next_core_clk = 1'b0;
        next_core_iso = 1'b1;
        next_core_pwr = 1'b0;
        next_core_rst = 1'b1;
        next_mem_pwr = 1'b0;
        next_per_pwr = 1'b0;
        next_per_clk = 1'b0;
        next_cold_boot = 1'b1;
      end
      pmseq_pkg::PMSEQ_ST_UP_ON, pmseq_pkg::PMSEQ_ST_UP_RST: begin
        next_core_clk = 1'b0;
        next_core_iso = 1'b1;
        next_core_rst = 1'b1;
        // retention held after sleep through power-up and reset hold, so contents survive
        next_mem_ret = ~from_shutdown;
      end
      pmseq_pkg::PMSEQ_ST_UP_CLK: begin
        next_core_clk = 1'b0;
        next_core_rst = 1'b1;
      end
      default: begin
        next_core_clk = 1'b1;
      end
    endcase
    if (state == pmseq_pkg::PMSEQ_ST_ACTIVE && MODE_REQ_I) begin
      // new request: boot flag only tells the latest return
      next_cold_boot = 1'b0;
    end
    if (next_state == pmseq_pkg::PMSEQ_ST_UP_ON && !from_shutdown) begin
      next_cold_boot = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // always-on registers: run on the system clock, never power-gated
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      state <= pmseq_pkg::PMSEQ_ST_ACTIVE;
      cnt <= pmseq_pkg::CNT_ZERO;
      from_shutdown <= 1'b0;
      cause <= '0;
      mode <= pmseq_pkg::PMSEQ_MODE_ACTIVE;
      core_pwr <= 1'b1;
      core_clk <= 1'b1;
      core_iso <= 1'b0;
      core_rst <= 1'b0;
      mem_pwr <= 1'b1;
      mem_ret <= 1'b0;
      per_pwr <= 1'b1;
      per_clk <= 1'b1;
      cold_boot <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      from_shutdown <= next_from_shutdown;
      cause <= next_cause;
      mode <= next_mode;
      core_pwr <= next_core_pwr;
      core_clk <= next_core_clk;
      core_iso <= next_core_iso;
      core_rst <= next_core_rst;
      mem_pwr <= next_mem_pwr;
      mem_ret <= next_mem_ret;
      per_pwr <= next_per_pwr;
      per_clk <= next_per_clk;
      cold_boot <= next_cold_boot;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // standby wake must not wait a cycle, so clock enable bypasses the flop
  assign CORE_CLK_EN_O = core_clk | ((state == pmseq_pkg::PMSEQ_ST_STBY) & SYS_IRQ_I);
  assign CORE_PWR_EN_O = core_pwr;
  assign CORE_ISO_O = core_iso;
  assign CORE_RST_O = core_rst;
  assign COLD_BOOT_O = cold_boot;
  assign MEM_PWR_EN_O = mem_pwr;
  assign MEM_RET_O = mem_ret;
  assign PERIPH_PWR_EN_O = per_pwr;
  assign PERIPH_CLK_EN_O = per_clk;
  assign MODE_O = mode;
  assign BUSY_O = (state != pmseq_pkg::PMSEQ_ST_ACTIVE) && (state != pmseq_pkg::PMSEQ_ST_STBY)
                  && (state != pmseq_pkg::PMSEQ_ST_SLEEP) && (state != pmseq_pkg::PMSEQ_ST_SHUTDOWN);
  assign WAKE_CAUSE_O = cause;

endmodule

// *** common/pmseq_pkg.sv ***
// power mode sequencer package: modes, states, sequencing counts
// assumes a 20 MHz system clock that never stops (sequencer is always-on)
package pmseq_pkg;

  // mode request encoding on the mode-select input
  typedef enum logic [1:0] {
    PMSEQ_MODE_ACTIVE   = 2'b00,
    PMSEQ_MODE_STANDBY  = 2'b01,
    PMSEQ_MODE_SLEEP    = 2'b10,
    PMSEQ_MODE_SHUTDOWN = 2'b11
  } pmseq_mode_t;

  // sequencer states
  typedef enum logic [3:0] {
    PMSEQ_ST_ACTIVE     = 4'h0,
    PMSEQ_ST_STBY       = 4'h1,
    PMSEQ_ST_SLP_ISO    = 4'h2,
    PMSEQ_ST_SLP_RET    = 4'h3,
    PMSEQ_ST_SLP_OFF    = 4'h4,
    PMSEQ_ST_SLEEP      = 4'h5,
    PMSEQ_ST_SHD_ISO    = 4'h6,
    PMSEQ_ST_SHD_OFF    = 4'h7,
    PMSEQ_ST_SHUTDOWN   = 4'h8,
    PMSEQ_ST_UP_ON      = 4'h9,
    PMSEQ_ST_UP_RST     = 4'hA,
    PMSEQ_ST_UP_CLK     = 4'hB
  } pmseq_state_t;

  localparam int CLK_HZ = 20000000;
  // settle time after each power switch step, in ns
  localparam int SETTLE_NS = 500;
  localparam int SETTLE_CYC_RAW = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0] SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 8'h01 : 8'(SETTLE_CYC_RAW);
  // core reset hold after power-up, in ns
  localparam int RST_HOLD_NS = 1000;
  localparam int RST_HOLD_CYC_RAW = (RST_HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0] RST_HOLD_CYC = (RST_HOLD_CYC_RAW < 1) ? 8'h01 : 8'(RST_HOLD_CYC_RAW);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;

  // wake source count: external pins plus internal timers
  localparam int NUM_EXT_WAKE = 4;
  localparam int NUM_TMR_WAKE = 2;

endpackage

// *** logic/pmseq_wake_gate.sv ***
// pmseq_wake_gate: per-source wake enable and sticky latch
// assumes sources are synchronous levels/pulses on the system clock
`timescale 1ns/1ps
module pmseq_wake_gate #(
  parameter int N = 6
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // wake sources
  input wire logic [N-1:0] src_i,
  input wire logic [N-1:0] enable_i,
  input wire logic arm_i,
  input wire logic clear_i,
  // result
  output logic [N-1:0] latched_o,
  output logic wake_o
);

  logic [N-1:0] latched;
  logic [N-1:0] next_latched;

  ////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      // set beats clear so an edge in the clear cycle is kept
      always_comb begin
        next_latched[g] = latched[g];
        if (clear_i) begin
          next_latched[g] = 1'b0;
        end
        if (arm_i && enable_i[g] && src_i[g]) begin
          next_latched[g] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      latched <= '0;
    end else begin
      latched <= next_latched;
    end
  end

  assign latched_o = latched;
  assign wake_o = |latched;

endmodule

// *** tb/pmseq_core_model.sv ***
// pmseq_core_model: behavioural core as seen from the sequencer outputs
// assumes the sequencer drives power, clock, reset and boot kind
`timescale 1ns/1ps
module pmseq_core_model (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // core domain control
  input wire logic CORE_PWR_EN_I,
  input wire logic CORE_CLK_EN_I,
  input wire logic CORE_RST_I,
  input wire logic COLD_BOOT_I,
  // status
  output logic run_o,
  output int boots_o
);
  logic rst_q;
  ////////////////////////////////////////////////////////////////////////
  // executes whenever powered, clocked and out of reset
  assign run_o = CORE_PWR_EN_I & CORE_CLK_EN_I & ~CORE_RST_I;
  // flash reload counted only on cold release; warm release keeps memory
  always @(posedge SYS_CLK_I) begin
    rst_q <= CORE_RST_I;
    if (RESET_I) begin
      boots_o <= 0;
    end else if (rst_q && !CORE_RST_I && COLD_BOOT_I) begin
      boots_o <= boots_o + 1;
    end
  end
endmodule

// *** tb/pmseq_top_checker.sv ***
// pmseq_top_checker: port-level assertions for the power mode sequencer
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module pmseq_top_checker (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [1:0] MODE_SEL_I,
  input wire logic MODE_REQ_I,
  input wire logic [pmseq_pkg::NUM_EXT_WAKE-1:0] EXT_IRQ_I,
  input wire logic [pmseq_pkg::NUM_TMR_WAKE-1:0] TMR_IRQ_I,
  input wire logic [pmseq_pkg::NUM_EXT_WAKE+pmseq_pkg::NUM_TMR_WAKE-1:0] WAKE_EN_I,
  input wire logic SYS_IRQ_I,
  input wire logic CORE_PWR_EN_O,
  input wire logic CORE_CLK_EN_O,
  input wire logic CORE_ISO_O,
  input wire logic CORE_RST_O,
  input wire logic COLD_BOOT_O,
  input wire logic MEM_PWR_EN_O,
  input wire logic MEM_RET_O,
  input wire logic PERIPH_PWR_EN_O,
  input wire logic PERIPH_CLK_EN_O,
  input wire logic [1:0] MODE_O,
  input wire logic BUSY_O,
  input wire logic [pmseq_pkg::NUM_EXT_WAKE+pmseq_pkg::NUM_TMR_WAKE-1:0] WAKE_CAUSE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  ////////////////////////////////////////////////////////////////////////
  stby_gate_a: assert property ((MODE_REQ_I && MODE_SEL_I == 2'h1 && MODE_O == 2'h0 && !BUSY_O) |=>
    ((!CORE_CLK_EN_O || SYS_IRQ_I) && CORE_PWR_EN_O && MODE_O == 2'h1)) else $error("standby entry wrong");
  stby_wake_a: assert property ((MODE_O == 2'h1 && !BUSY_O && SYS_IRQ_I) |-> CORE_CLK_EN_O ##1 MODE_O == 2'h0)
    else $error("standby exit not immediate");
  down_start_a: assert property ((MODE_REQ_I && MODE_SEL_I[1] && MODE_O == 2'h0 && !BUSY_O) |=>
    (BUSY_O && CORE_ISO_O && !CORE_CLK_EN_O)) else $error("power-down not started");
  active_on_a: assert property ((MODE_O == 2'h0 && !BUSY_O) |-> (CORE_PWR_EN_O && CORE_CLK_EN_O &&
    PERIPH_PWR_EN_O && PERIPH_CLK_EN_O && MEM_PWR_EN_O && !CORE_RST_O)) else $error("active not fully on");
  sleep_ret_a: assert property ((MODE_O == 2'h2 && !BUSY_O) |-> (!CORE_PWR_EN_O && MEM_RET_O && CORE_ISO_O))
    else $error("sleep retention wrong");
  shut_off_a: assert property ((MODE_O == 2'h3 && !BUSY_O) |->
    (!CORE_PWR_EN_O && !MEM_PWR_EN_O && !PERIPH_PWR_EN_O)) else $error("shutdown left power on");
  wake_go_a: assert property ((MODE_O[1] && !BUSY_O && |(WAKE_EN_I & {TMR_IRQ_I, EXT_IRQ_I})) |-> ##[1:3] BUSY_O)
    else $error("wake not started");
  wake_done_a: assert property ($rose(CORE_PWR_EN_O) |-> ##33 (MODE_O == 2'h0 && !BUSY_O && CORE_CLK_EN_O))
    else $error("wake not completed");
endmodule
bind pmseq_top pmseq_top_checker pmseq_top_checker_i (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
  .MODE_SEL_I(MODE_SEL_I), .MODE_REQ_I(MODE_REQ_I), .EXT_IRQ_I(EXT_IRQ_I), .TMR_IRQ_I(TMR_IRQ_I),
  .WAKE_EN_I(WAKE_EN_I), .SYS_IRQ_I(SYS_IRQ_I), .CORE_PWR_EN_O(CORE_PWR_EN_O), .CORE_CLK_EN_O(CORE_CLK_EN_O),
  .CORE_ISO_O(CORE_ISO_O), .CORE_RST_O(CORE_RST_O), .COLD_BOOT_O(COLD_BOOT_O), .MEM_PWR_EN_O(MEM_PWR_EN_O),
  .MEM_RET_O(MEM_RET_O), .PERIPH_PWR_EN_O(PERIPH_PWR_EN_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
  .MODE_O(MODE_O), .BUSY_O(BUSY_O), .WAKE_CAUSE_O(WAKE_CAUSE_O));

// *** tb/testbench.sv ***
// testbench: mode requests, standby exit, sleep and shutdown wakes
// assumes pmseq_top with its package, core model and bound checker
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] sel = 2'h0;
  logic req = 1'b0;
  logic [5:0] src = 6'h00;
  logic [5:0] wen = 6'h00;
  logic sys_irq = 1'b0;
  logic core_pwr, core_clk, core_iso, core_rst, cold, mem_pwr, mem_ret, per_pwr, per_clk, busy, run;
  logic [1:0] mode;
  logic [5:0] cause;
  int boots;
  int mismatches = 0;
  int n_checks = 0;
  int exp_mode, exp_cold, exp_cause, exp_boots, b;
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  pmseq_top pmseq_top_i (.SYS_CLK_I(clk), .RESET_I(rst), .MODE_SEL_I(sel), .MODE_REQ_I(req),
    .EXT_IRQ_I(src[3:0]), .TMR_IRQ_I(src[5:4]), .WAKE_EN_I(wen), .SYS_IRQ_I(sys_irq),
    .CORE_PWR_EN_O(core_pwr), .CORE_CLK_EN_O(core_clk), .CORE_ISO_O(core_iso), .CORE_RST_O(core_rst),
    .COLD_BOOT_O(cold), .MEM_PWR_EN_O(mem_pwr), .MEM_RET_O(mem_ret), .PERIPH_PWR_EN_O(per_pwr),
    .PERIPH_CLK_EN_O(per_clk), .MODE_O(mode), .BUSY_O(busy), .WAKE_CAUSE_O(cause));
  pmseq_core_model pmseq_core_model_i (.SYS_CLK_I(clk), .RESET_I(rst), .CORE_PWR_EN_I(core_pwr),
    .CORE_CLK_EN_I(core_clk), .CORE_RST_I(core_rst), .COLD_BOOT_I(cold), .run_o(run), .boots_o(boots));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic request(input logic [1:0] m);
    @(posedge clk);
    sel <= m;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    #1;
  endtask
  task automatic pulse_src(input int n);
    @(posedge clk);
    src[n] <= 1'b1;
    @(posedge clk);
    src <= 6'h00;
    #1;
  endtask
  // bounded wait for a settled mode
  task automatic settle(input logic [1:0] m);
    int i;
    for (i = 0; i < 200 && !(busy === 1'b0 && mode === m); i++) begin
      cyc(1);
    end
    if (!(busy === 1'b0 && mode === m)) begin
      mismatches++;
      $display("[FAIL] settle expected %h seen %h", m, mode);
      finish_test();
    end
  endtask
  // model state compared at every result
  task automatic compare_all();
    check("mode", {6'h00, mode}, exp_mode[7:0]);
    check("cold boot", {7'h00, cold}, exp_cold[7:0]);
    check("wake cause", {2'h0, cause}, exp_cause[7:0]);
    check("boots", boots[7:0], exp_boots[7:0]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h63A029F5));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    exp_mode = 0;
    exp_cold = 1;
    exp_cause = 0;
    exp_boots = 0;
    compare_all();
    check("enables", {core_pwr, core_clk, per_pwr, per_clk, mem_pwr, mem_ret, core_iso, core_rst}, 8'hF8);
    $display("test reset done");
    // null request keeps mode and busy unchanged; requests outside active are dropped silently
    request(2'h0);
    cyc(3);
    check("null req busy", {7'h00, busy}, 8'h00);
    check("null req mode", {6'h00, mode}, exp_mode[7:0]);
    // any request taken in active drops the boot flag, even a null one
    exp_cold = 0;
    request(2'h1);
    exp_mode = 1;
    check("stby clk", {6'h00, core_pwr, core_clk}, 8'h02);
    check("stby run", {7'h00, run}, 8'h00);
    request(2'h2);
    cyc(2);
    check("stby mode", {6'h00, mode}, exp_mode[7:0]);
    @(posedge clk);
    sys_irq <= 1'b1;
    #1;
    check("stby ungate", {7'h00, core_clk}, 8'h01);
    check("stby resume", {7'h00, run}, 8'h01);
    @(posedge clk);
    sys_irq <= 1'b0;
    #1;
    exp_mode = 0;
    compare_all();
    $display("test standby done");
    // sleep, a wake during power-down must be dropped, not queued
    @(posedge clk);
    wen <= 6'h3F;
    request(2'h2);
    pulse_src($urandom_range(3, 0));
    settle(2'h2);
    exp_mode = 2;
    check("sleep dom", {5'h00, core_pwr, mem_ret, core_iso}, 8'h03);
    cyc(5);
    check("sleep hold", {5'h00, busy, mode}, exp_mode[7:0]);
    b = $urandom_range(3, 0);
    pulse_src(b);
    settle(2'h0);
    exp_mode = 0;
    exp_cold = 0;
    exp_cause = 1 << b;
    compare_all();
    check("sleep resume", {7'h00, run}, 8'h01);
    $display("test sleep done");
    // shutdown, disabled timer first, then an enabled one
    request(2'h3);
    settle(2'h3);
    exp_mode = 3;
    check("shd power", {5'h00, core_pwr, mem_pwr, per_pwr}, 8'h00);
    @(posedge clk);
    wen <= 6'h0F;
    pulse_src(4);
    cyc(5);
    check("disabled src", {5'h00, busy, mode}, exp_mode[7:0]);
    @(posedge clk);
    wen <= 6'h3F;
    b = 4 + $urandom_range(1, 0);
    pulse_src(b);
    settle(2'h0);
    exp_mode = 0;
    exp_cold = 1;
    exp_cause = 1 << b;
    exp_boots = 1;
    cyc(2);
    compare_all();
    $display("test shutdown done");
    finish_test();
  end
endmodule
